// >>> src/hbridge_params.svh
// Timing, reset and field constants for the H-bridge control block
// Overview of operation
// [RL1] Bridge switches follow either the drive pins or SPI bits, chosen by configuration
// [RL2] Enable pin is active high, disable pin active high; both must enable
// [RL3] Disable pin is an input after reset; flag mode bit makes it open-drain flag
// [RL4] Configuration writes and reads work whatever the disable pin is doing
// [RL5] Open drive and disable pins read high, open enable reads low, giving Hi-Z
// [RL6] Enabled and fault free, each output follows its drive input
// [RL7] In input mode a high disable pin forces both outputs Hi-Z
// [RL8] Both channel enable bits reset to one; drive needs both set
// [RL9] Flag released in normal drive and limiting, low on disable, undervoltage, faults
// [RL10] Peak current level comes from a configuration field; thresholds track it
// [RL11] Limit held for blanking time: low side off, high side on, peak flag latched
// [RL12] Peak limiting never pulls the status flag low
// [RL13] Low side shutdown past filter delay within blanking: short to supply lockout
// [RL14] High side shutdown past filter delay: short to ground lockout
// [RL15] Low side limit with opposite high side shutdown together: shorted load lockout
// [RL16] Overtemperature latches transistors off, flag and overtemperature bit
// [RL17] Lockout leaves on enable rise with disable low, or disable fall with enable high
// [RL18] In flag mode flag falls with enable falling and releases with enable rising
// [RL19] Outputs drive only with enable high, disable low and both channel bits set
// [RL20] Pins and comparator inputs are synchronised before use
// [RL21] Lockout is sticky, overrides drive decoding and holds outputs Hi-Z
`ifndef HBRIDGE_PARAMS_SVH
`define HBRIDGE_PARAMS_SVH

`define HB_CLK_MHZ       125
`define HB_BLANK_NS      3000
`define HB_FILTER_NS     1000
`define HB_RECIRC_NS     20000
`define HB_BLANK_CYC     ((`HB_BLANK_NS * `HB_CLK_MHZ + 999) / 1000)
`define HB_FILTER_CYC    ((`HB_FILTER_NS * `HB_CLK_MHZ + 999) / 1000)
`define HB_RECIRC_CYC    ((`HB_RECIRC_NS * `HB_CLK_MHZ) / 1000)
`define HB_LIMIT_W       2
`define HB_LIMIT_RST     2'h0
`define HB_CHAN_EN_RST   2'h3
`define HB_FLAG_MODE_RST 1'b0
`define HB_SPI_SEL_RST   1'b0
`define HB_PIN_RST       4'hB
`define HB_CMP_RST       8'h00

`endif

// >>> src/hbridge_pkg.sv
// Types shared by the H-bridge control block
package hbridge_pkg;
  typedef enum logic [2:0] {
    ST_STANDBY = 3'h1,
    ST_ACTIVE  = 3'h2,
    ST_LOCKOUT = 3'h4
  } bridge_state_e;
endpackage

// >>> src/pin_sync.sv
// Three-stage input synchroniser with agreement filter
`timescale 1ns/1ps
module pin_sync #(
  parameter int           W   = 1,
  parameter logic [W-1:0] RST = '0
) (
  input  wire logic         clk,
  input  wire logic         rst_n,
  input  wire logic [W-1:0] asyncIn,
  output logic      [W-1:0] stable
);
  logic [W-1:0] stage1_ff;
  logic [W-1:0] stage2_ff;
  logic [W-1:0] stage3_ff;
  logic [W-1:0] stable_ff;
  logic [W-1:0] nxt_stable;

  // A change is taken only once stages two and three agree
  for (genvar i = 0; i < W; i++) begin : g_bit
    assign nxt_stable[i] = (stage2_ff[i] == stage3_ff[i]) ? stage3_ff[i] : stable_ff[i]; // [RL20]
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      stage1_ff <= RST;
      stage2_ff <= RST;
      stage3_ff <= RST;
      stable_ff <= RST;
    end else begin
      stage1_ff <= asyncIn;
      stage2_ff <= stage1_ff;
      stage3_ff <= stage2_ff;
      stable_ff <= nxt_stable;
    end
  end

  assign stable = stable_ff;
endmodule // pin_sync

// >>> src/fault_filter.sv
// Saturating duration filter: flags a level held for N cycles
`timescale 1ns/1ps
module fault_filter #(
  parameter int N = 4
) (
  input  wire logic clk,
  input  wire logic rst_n,
  input  wire logic level,
  output logic      expired
);
  localparam int CW = $clog2(N + 1);

  logic [CW-1:0] count_ff;
  logic [CW-1:0] nxt_count;

  assign expired   = (count_ff >= CW'(N));
  assign nxt_count = !level ? '0 : (expired ? count_ff : count_ff + 1'b1);

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      count_ff <= '0;
    end else begin
      count_ff <= nxt_count;
    end
  end
endmodule // fault_filter

// >>> src/hbridge_control_and_fault_lockout.sv
// H-bridge drive decoding, current limiting and fault lockout
`timescale 1ns/1ps
`include "hbridge_params.svh"
module hbridge_control_and_fault_lockout #(
  parameter int BLANK_CYC  = `HB_BLANK_CYC,
  parameter int FILTER_CYC = `HB_FILTER_CYC,
  parameter int RECIRC_CYC = `HB_RECIRC_CYC,
  parameter int LIMIT_W    = `HB_LIMIT_W
) (
  input  wire logic               clk,
  input  wire logic               rst_n,
  input  wire logic               bridgeDriveInputA,
  input  wire logic               bridgeDriveInputB,
  input  wire logic               enablePin,
  input  wire logic               disFlagIn,
  output logic                    disFlagOut,
  output logic                    disFlagOe,
  input  wire logic               cfgWrite,
  input  wire logic               cfgDriveBySpi,
  input  wire logic               cfgSpiDriveA,
  input  wire logic               cfgSpiDriveB,
  input  wire logic               cfgFlagMode,
  input  wire logic               cfgChannelEnableA,
  input  wire logic               cfgChannelEnableB,
  input  wire logic [LIMIT_W-1:0] cfgLimitSelect,
  input  wire logic               diagClear,
  input  wire logic [1:0]         lsOverLimit,
  input  wire logic [1:0]         lsOverShutdown,
  input  wire logic [1:0]         hsOverShutdown,
  input  wire logic               overTempShutdown,
  input  wire logic               supplyUndervoltage,
  output logic      [1:0]         highSideOn,
  output logic      [1:0]         lowSideOn,
  output logic                    driveBySpi,
  output logic                    flagModeSelect,
  output logic      [1:0]         channelEnableBits,
  output logic      [LIMIT_W-1:0] currentLimitSelect,
  output logic      [1:0]         peakLimitSeen,
  output logic      [1:0]         shortToSupplySeen,
  output logic      [1:0]         shortToGroundSeen,
  output logic                    overloadSeen,
  output logic                    overtempSeen,
  output logic                    lockoutActive
);
  localparam int RW = $clog2(RECIRC_CYC + 1);

  // ==========================================================
  // Input synchronisation
  // ==========================================================
  logic [3:0] pinStable;
  logic [7:0] cmpStable;

  // Reset levels match the pin pulls: drive and disable high, enable low
  pin_sync #(.W(4), .RST(`HB_PIN_RST)) u_pinSync ( // [RL5] [RL20]
    .clk     (clk),
    .rst_n   (rst_n),
    .asyncIn ({disFlagIn, enablePin, bridgeDriveInputB, bridgeDriveInputA}),
    .stable  (pinStable)
  );

  pin_sync #(.W(8), .RST(`HB_CMP_RST)) u_cmpSync ( // [RL20]
    .clk     (clk),
    .rst_n   (rst_n),
    .asyncIn ({supplyUndervoltage, overTempShutdown, hsOverShutdown, lsOverShutdown, lsOverLimit}),
    .stable  (cmpStable)
  );

  wire [1:0] limitHit = cmpStable[1:0];
  wire [1:0] lsSdHit  = cmpStable[3:2];
  wire [1:0] hsSdHit  = cmpStable[5:4];
  wire       tempHit  = cmpStable[6];
  wire       uvHit    = cmpStable[7];

  // ==========================================================
  // Configuration
  // ==========================================================
  logic               spiSel_ff;
  logic [1:0]         spiDrive_ff;
  logic               flagMode_ff;
  logic [1:0]         chanEn_ff;
  logic [LIMIT_W-1:0] limitSel_ff;

  // Writes are taken regardless of the disable pin
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      spiSel_ff   <= `HB_SPI_SEL_RST;
      spiDrive_ff <= 2'h0;
      flagMode_ff <= `HB_FLAG_MODE_RST; // [RL3]
      chanEn_ff   <= `HB_CHAN_EN_RST; // [RL8]
      limitSel_ff <= `HB_LIMIT_RST;
    end else if (cfgWrite) begin // [RL4]
      spiSel_ff   <= cfgDriveBySpi;
      spiDrive_ff <= {cfgSpiDriveB, cfgSpiDriveA};
      flagMode_ff <= cfgFlagMode; // [RL3]
      chanEn_ff   <= {cfgChannelEnableB, cfgChannelEnableA};
      limitSel_ff <= cfgLimitSelect;
    end
  end

  assign driveBySpi         = spiSel_ff;
  assign flagModeSelect     = flagMode_ff;
  assign channelEnableBits  = chanEn_ff;
  assign currentLimitSelect = limitSel_ff; // [RL10]

  // ==========================================================
  // Enable decoding and re-enable edges
  // ==========================================================
  logic enPrev_ff;
  logic disPrev_ff;

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      enPrev_ff  <= 1'b0;
      disPrev_ff <= 1'b1;
    end else begin
      enPrev_ff  <= pinStable[2];
      disPrev_ff <= pinStable[3];
    end
  end

  // In flag mode the pin is our own output and is not a disable
  wire enLvl      = pinStable[2];
  wire disLvl     = !flagMode_ff & pinStable[3]; // [RL3] [RL7]
  wire enRise     = enLvl & !enPrev_ff;
  wire disFall    = !flagMode_ff & !pinStable[3] & disPrev_ff;
  wire reEnable   = (enRise & !disLvl) | (disFall & enLvl); // [RL17]
  wire enableOk   = enLvl & !disLvl & (&chanEn_ff); // [RL2] [RL19] [RL8]
  wire [1:0] cmd  = spiSel_ff ? spiDrive_ff : pinStable[1:0]; // [RL1]

  // ==========================================================
  // Per-side protection
  // ==========================================================
  logic [1:0] hs_ff;
  logic [1:0] ls_ff;
  logic [1:0] peakExp;
  logic [1:0] lsSdExp;
  logic [1:0] hsSdExp;
  logic [1:0] peakHit;
  logic [1:0] shortSupply;
  logic [1:0] shortGround;
  logic [1:0] overload;
  logic [1:0] recircBusy;

  for (genvar i = 0; i < 2; i++) begin : g_side
    logic [RW-1:0] recirc_ff;
    logic [RW-1:0] nxt_recirc;

    fault_filter #(.N(BLANK_CYC)) u_peak (
      .clk     (clk),
      .rst_n   (rst_n),
      .level   (limitHit[i] & ls_ff[i]),
      .expired (peakExp[i])
    );

    fault_filter #(.N(FILTER_CYC)) u_lsSd (
      .clk     (clk),
      .rst_n   (rst_n),
      .level   (lsSdHit[i]),
      .expired (lsSdExp[i])
    );

    fault_filter #(.N(FILTER_CYC)) u_hsSd (
      .clk     (clk),
      .rst_n   (rst_n),
      .level   (hsSdHit[i]),
      .expired (hsSdExp[i])
    );

    assign peakHit[i]     = peakExp[i] & ls_ff[i]; // [RL11]
    assign shortSupply[i] = lsSdExp[i] & !peakExp[i]; // [RL13]
    assign shortGround[i] = hsSdExp[i]; // [RL14]
    assign overload[i]    = limitHit[i] & hsSdHit[1-i]; // [RL15]
    assign recircBusy[i]  = (recirc_ff != '0);
    assign nxt_recirc     = peakHit[i] ? RW'(RECIRC_CYC) :
                            recircBusy[i] ? recirc_ff - 1'b1 : '0; // [RL11]

    always_ff @(posedge clk) begin
      if (!rst_n) begin
        recirc_ff <= '0;
      end else begin
        recirc_ff <= nxt_recirc;
      end
    end
  end

  wire anyFault = (|shortSupply) | (|shortGround) | (|overload) | tempHit;

  // ==========================================================
  // Bridge state
  // ==========================================================
  hbridge_pkg::bridge_state_e state_ff;
  hbridge_pkg::bridge_state_e nxt_state;

  always_comb begin
    nxt_state = state_ff;
    case (state_ff)
      hbridge_pkg::ST_STANDBY: begin
        if (anyFault) begin
          nxt_state = hbridge_pkg::ST_LOCKOUT;
        end else if (enableOk & !uvHit) begin
          nxt_state = hbridge_pkg::ST_ACTIVE;
        end
      end
      hbridge_pkg::ST_ACTIVE: begin
        if (anyFault) begin
          nxt_state = hbridge_pkg::ST_LOCKOUT; // [RL13] [RL14] [RL15] [RL16]
        end else if (!enableOk | uvHit) begin
          nxt_state = hbridge_pkg::ST_STANDBY; // [RL19]
        end
      end
      hbridge_pkg::ST_LOCKOUT: begin
        if (reEnable & !anyFault) begin
          nxt_state = hbridge_pkg::ST_STANDBY; // [RL17] [RL21]
        end
      end
      default: begin
        nxt_state = hbridge_pkg::ST_LOCKOUT;
      end
    endcase
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      state_ff <= hbridge_pkg::ST_STANDBY;
    end else begin
      state_ff <= nxt_state;
    end
  end

  // ==========================================================
  // Output stage drive
  // ==========================================================
  // Lockout, standby and any live fault or undervoltage all give Hi-Z
  wire driveOn = (state_ff == hbridge_pkg::ST_ACTIVE) & enableOk & !uvHit & !anyFault; // [RL21] [RL7]

  // High level: high side on; low level: low side on; recirculation swaps
  wire [1:0] nxt_hs = {2{driveOn}} & (cmd | recircBusy | peakHit); // [RL6] [RL11]
  wire [1:0] nxt_ls = {2{driveOn}} & ~cmd & ~recircBusy & ~peakHit; // [RL6] [RL11]

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      hs_ff <= 2'h0;
      ls_ff <= 2'h0;
    end else begin
      hs_ff <= nxt_hs;
      ls_ff <= nxt_ls;
    end
  end

  assign highSideOn    = hs_ff;
  assign lowSideOn     = ls_ff;
  assign lockoutActive = (state_ff == hbridge_pkg::ST_LOCKOUT);

  // ==========================================================
  // Status flag pin
  // ==========================================================
  logic flagLow_ff;

  // Peak limiting is deliberately absent from the flag terms
  wire nxt_flagLow = flagMode_ff & (!enLvl | uvHit | anyFault | lockoutActive); // [RL9] [RL12] [RL18]

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      flagLow_ff <= 1'b0;
    end else begin
      flagLow_ff <= nxt_flagLow;
    end
  end

  assign disFlagOut = 1'b0;
  assign disFlagOe  = flagLow_ff;

  // ==========================================================
  // Diagnostic latches
  // ==========================================================
  logic [1:0] peakSeen_ff;
  logic [1:0] stsSeen_ff;
  logic [1:0] stgSeen_ff;
  logic       ovlSeen_ff;
  logic       tempSeen_ff;

  // Set wins over a clear in the same cycle
  wire [1:0] clr2 = {2{diagClear}};

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      peakSeen_ff <= 2'h0;
      stsSeen_ff  <= 2'h0;
      stgSeen_ff  <= 2'h0;
      ovlSeen_ff  <= 1'b0;
      tempSeen_ff <= 1'b0;
    end else begin
      peakSeen_ff <= (peakSeen_ff & ~clr2) | peakHit; // [RL11]
      stsSeen_ff  <= (stsSeen_ff & ~clr2) | shortSupply; // [RL13]
      stgSeen_ff  <= (stgSeen_ff & ~clr2) | shortGround; // [RL14]
      ovlSeen_ff  <= (ovlSeen_ff & !diagClear) | (|overload); // [RL15]
      tempSeen_ff <= (tempSeen_ff & !diagClear) | tempHit; // [RL16]
    end
  end

  assign peakLimitSeen     = peakSeen_ff;
  assign shortToSupplySeen = stsSeen_ff;
  assign shortToGroundSeen = stgSeen_ff;
  assign overloadSeen      = ovlSeen_ff;
  assign overtempSeen      = tempSeen_ff;

  // ==========================================================
  // Assertions
  // ==========================================================
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);

  lockout_hiz_a: assert property (lockoutActive |=> (highSideOn == 2'h0) && (lowSideOn == 2'h0)) // [RL21]
    else $error("Outputs driven during lockout");

  fault_lock_a: assert property (anyFault |=> lockoutActive) // [RL13]
    else $error("Fault did not enter lockout");

  overtemp_latch_a: assert property (tempHit |=> overtempSeen && lockoutActive && (highSideOn == 2'h0)) // [RL16]
    else $error("Overtemperature not latched");

  ground_latch_a: assert property (shortGround[0] |=> shortToGroundSeen[0] && lockoutActive) // [RL14]
    else $error("Short to ground not latched");

  overload_latch_a: assert property ((|overload) |=> overloadSeen ##1 (highSideOn == 2'h0)) // [RL15]
    else $error("Shorted load not latched");

  dis_hiz_a: assert property (!flagMode_ff && pinStable[3] |=> (highSideOn | lowSideOn) == 2'h0) // [RL7]
    else $error("Disable pin high but outputs drive");

  chan_off_a: assert property (!(&chanEn_ff) |=> (highSideOn | lowSideOn) == 2'h0) // [RL8]
    else $error("Channel bit cleared but outputs drive");

  flag_en_low_a: assert property (flagMode_ff && !enLvl |=> disFlagOe) // [RL18]
    else $error("Flag not low with enable low");

  flag_peak_a: assert property (flagMode_ff && driveOn && !uvHit && (|peakHit) |=> !disFlagOe) // [RL12]
    else $error("Peak limit pulled the flag low");

  peak_recirc_a: assert property (driveOn && (peakHit != 2'h0) // [RL11]
    |=> (highSideOn & ~lowSideOn & peakLimitSeen & $past(peakHit)) == $past(peakHit))
    else $error("Peak limit did not recirculate");

  follow_drive_a: assert property (driveOn && (recircBusy == 2'h0) && (peakHit == 2'h0) // [RL6]
    |=> (highSideOn == $past(cmd)) && (lowSideOn == ~$past(cmd)))
    else $error("Outputs do not follow drive inputs");

  reenable_a: assert property (lockoutActive && reEnable && !anyFault |=> !lockoutActive) // [RL17]
    else $error("Valid re-enable edge ignored");

  lock_sticky_a: assert property (lockoutActive && !reEnable |=> lockoutActive) // [RL21]
    else $error("Lockout left without re-enable");
endmodule // hbridge_control_and_fault_lockout

// >>> tb/host_mcu_model.sv
// Host side of the pins: host drivers, pin pulls and the shared open-drain line
`timescale 1ns/1ps
module host_mcu_model (
  input  wire logic hostEn,
  input  wire logic hostEnOe,
  input  wire logic hostDis,
  input  wire logic hostDisOe,
  input  wire logic hostInA,
  input  wire logic hostInB,
  input  wire logic hostInOe,
  input  wire logic disFlagOe,
  output logic      enablePin,
  output logic      disFlagIn,
  output logic      driveA,
  output logic      driveB
);
  // Released enable falls to its pull-down, released drive inputs rise to their pull-ups
  assign enablePin = hostEnOe ? hostEn : 1'h0;
  assign driveA    = hostInOe ? hostInA : 1'h1;
  assign driveB    = hostInOe ? hostInB : 1'h1;
  // Wired line: device pulls low, otherwise host level or pull-up
  assign disFlagIn = ~disFlagOe & (hostDisOe ? hostDis : 1'h1);
endmodule  // host_mcu_model

// >>> tb/tb_top.sv
// Self-checking bench for the H-bridge control and fault lockout block
`timescale 1ns/1ps
module tb_top;
  logic clk, rst_n, hostEn, hostEnOe, hostDis, hostDisOe, hostInA, hostInB, hostInOe;
  logic enablePin, disFlagIn, driveA, driveB, disFlagOut, disFlagOe, cfgWrite, diagClear;
  logic spiSel, spiA, spiB, flagMode, chA, chB, overTemp, underVolt;
  logic [1:0] limitSel, lsLimit, lsShut, hsShut, highSideOn, lowSideOn, chanBits, limitBack;
  logic [1:0] peakSeen, supplySeen, groundSeen;
  logic bySpiBack, flagBack, overloadSeen, overtempSeen, lockoutActive;
  int n_mismatch = 0;
  int tests_run = 0;
  int i;

  host_mcu_model host (.hostEn(hostEn), .hostEnOe(hostEnOe), .hostDis(hostDis), .hostDisOe(hostDisOe),
    .hostInA(hostInA), .hostInB(hostInB), .hostInOe(hostInOe), .disFlagOe(disFlagOe),
    .enablePin(enablePin), .disFlagIn(disFlagIn), .driveA(driveA), .driveB(driveB));

  hbridge_control_and_fault_lockout #(.BLANK_CYC(8), .FILTER_CYC(3), .RECIRC_CYC(5)) dut (
    .clk(clk), .rst_n(rst_n), .bridgeDriveInputA(driveA), .bridgeDriveInputB(driveB),
    .enablePin(enablePin), .disFlagIn(disFlagIn), .disFlagOut(disFlagOut), .disFlagOe(disFlagOe),
    .cfgWrite(cfgWrite), .cfgDriveBySpi(spiSel), .cfgSpiDriveA(spiA), .cfgSpiDriveB(spiB),
    .cfgFlagMode(flagMode), .cfgChannelEnableA(chA), .cfgChannelEnableB(chB),
    .cfgLimitSelect(limitSel), .diagClear(diagClear), .lsOverLimit(lsLimit), .lsOverShutdown(lsShut),
    .hsOverShutdown(hsShut), .overTempShutdown(overTemp), .supplyUndervoltage(underVolt),
    .highSideOn(highSideOn), .lowSideOn(lowSideOn), .driveBySpi(bySpiBack), .flagModeSelect(flagBack),
    .channelEnableBits(chanBits), .currentLimitSelect(limitBack), .peakLimitSeen(peakSeen),
    .shortToSupplySeen(supplySeen), .shortToGroundSeen(groundSeen), .overloadSeen(overloadSeen),
    .overtempSeen(overtempSeen), .lockoutActive(lockoutActive));

  initial begin
    clk = 1'h0;
    forever #4 clk = ~clk;
  end

  // ==========================================
  // Helpers
  task automatic chk(input logic [7:0] got, input logic [7:0] exp, input string msg);
    tests_run++;
    if (got !== exp) begin
      n_mismatch++;
      $display("unexpected at %0t: %s got %h exp %h", $time, msg, got, exp);
    end
  endtask

  task automatic cyc(input int n);
    repeat (n) @(negedge clk);
  endtask

  function automatic logic [7:0] gates(input logic a, input logic b);
    return {4'h0, b, a, ~b, ~a};
  endfunction

  task automatic chkGates(input logic [7:0] exp, input string msg);
    chk({4'h0, highSideOn, lowSideOn}, exp, msg);
  endtask

  task automatic cfg(input logic sel, input logic a, input logic b, input logic fm, input logic [1:0] ch,
                     input logic [1:0] lim);
    @(negedge clk);
    {spiSel, spiA, spiB, flagMode, chA, chB, limitSel} = {sel, a, b, fm, ch[0], ch[1], lim};
    cfgWrite = 1'h1;
    @(negedge clk);
    cfgWrite = 1'h0;
  endtask

  task automatic pins(input logic en, input logic dis, input logic a, input logic b);
    {hostEn, hostDis, hostInA, hostInB} = {en, dis, a, b};
    cyc(10);
  endtask

  task automatic test_done;
    $display("mismatches %0d comparisons %0d", n_mismatch, tests_run);
    if (n_mismatch == 0 && tests_run > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask

  // ==========================================
  // Scenarios
  task automatic t_reset;
    chk({bySpiBack, flagBack, chanBits, limitBack, disFlagOe, 1'h0}, 8'h30, "reset cfg");
    chkGates(8'h00, "reset gates");
  endtask

  task automatic t_drive;
    for (i = 0; i < 4; i++) begin
      pins(1'h1, 1'h0, i[0], i[1]);
      chkGates(gates(i[0], i[1]), "follow");
    end
    hostInOe = 1'h0;
    cyc(10);
    chkGates(gates(1'h1, 1'h1), "open drive");
    hostInOe = 1'h1;
  endtask

  task automatic t_disable;
    pins(1'h1, 1'h1, 1'h1, 1'h0);
    chkGates(8'h00, "dis high");
    pins(1'h0, 1'h0, 1'h1, 1'h0);
    chkGates(8'h00, "en low");
    hostEn = 1'h1;
    hostDisOe = 1'h0;
    cyc(10);
    chkGates(8'h00, "dis open");
    hostDisOe = 1'h1;
    hostEnOe = 1'h0;
    cyc(10);
    chkGates(8'h00, "en open");
    hostEnOe = 1'h1;
    cfg(1'h0, 1'h0, 1'h0, 1'h0, 2'h1, 2'h0);
    cyc(10);
    chkGates(8'h00, "chan off");
    cfg(1'h0, 1'h0, 1'h0, 1'h0, 2'h3, 2'h0);
    cyc(10);
    chkGates(gates(1'h1, 1'h0), "chan on");
  endtask

  task automatic t_spi;
    cfg(1'h1, 1'h0, 1'h1, 1'h0, 2'h3, 2'h2);
    chk({bySpiBack, 5'h0, limitBack}, 8'h82, "spi cfg");
    cyc(10);
    chkGates(gates(1'h0, 1'h1), "spi drive");
    cfg(1'h0, 1'h0, 1'h0, 1'h0, 2'h3, 2'h0);
  endtask

  task automatic t_flag;
    pins(1'h1, 1'h1, 1'h1, 1'h0);
    cfg(1'h0, 1'h0, 1'h0, 1'h1, 2'h3, 2'h0);
    chk({7'h0, flagBack}, 8'h01, "flag mode");
    hostDisOe = 1'h0;
    cyc(10);
    chk({7'h0, disFlagOe}, 8'h00, "flag idle");
    chkGates(gates(1'h1, 1'h0), "flag drive");
    pins(1'h0, 1'h1, 1'h1, 1'h0);
    chk({5'h0, disFlagIn, disFlagOut, disFlagOe}, 8'h01, "flag en low");
    pins(1'h1, 1'h1, 1'h1, 1'h0);
    chk({7'h0, disFlagOe}, 8'h00, "flag en high");
    underVolt = 1'h1;
    cyc(10);
    chk({3'h0, disFlagOe, highSideOn, lowSideOn}, 8'h10, "uv");
    underVolt = 1'h0;
    cyc(12);
    chk({3'h0, disFlagOe, highSideOn, lowSideOn}, gates(1'h1, 1'h0), "uv gone");
    lsLimit = 2'h2;
    for (i = 0; i < 40 && lowSideOn[1] !== 1'h0; i++) @(negedge clk);
    chk({1'h0, disFlagOe, peakSeen, highSideOn, lowSideOn}, 8'h2C, "peak");
    lsLimit = 2'h0;
    cyc(20);
    chk({2'h0, peakSeen, highSideOn, lowSideOn}, 8'h26, "recirc end");
    diagClear = 1'h1;
    cyc(1);
    diagClear = 1'h0;
    cyc(1);
    chk({6'h0, peakSeen}, 8'h00, "clear");
  endtask

  task automatic t_fault(input int k);
    logic [5:0] exp;
    logic [5:0] seen;
    exp = 6'h01 << (k == 1 ? 3 : k == 2 ? 4 : k == 3 ? 5 : 0);
    cfg(1'h0, 1'h0, 1'h0, k == 0, 2'h3, 2'h0);
    hostDisOe = (k != 0);
    pins(1'h1, 1'h0, k != 2, k == 2);
    case (k)
      0: hsShut = 2'h1;
      1: lsShut = 2'h2;
      2: {lsLimit, hsShut} = 4'h6;
      default: overTemp = 1'h1;
    endcase
    for (i = 0; i < 30 && lockoutActive !== 1'h1; i++) @(negedge clk);
    {lsLimit, lsShut, hsShut, overTemp} = 7'h00;
    cyc(12);
    seen = {overtempSeen, overloadSeen, supplySeen, groundSeen};
    chk({2'h0, exp & seen}, {2'h0, exp}, "diag");
    chk({lockoutActive, 2'h0, disFlagOe, highSideOn, lowSideOn}, {1'h1, 2'h0, k == 0, 4'h0}, "lock");
    if (k[0]) begin
      pins(1'h1, 1'h1, k != 2, k == 2);
      pins(1'h1, 1'h0, k != 2, k == 2);
    end else begin
      pins(1'h0, 1'h0, k != 2, k == 2);
      pins(1'h1, 1'h0, k != 2, k == 2);
    end
    chk({lockoutActive, 3'h0, highSideOn, lowSideOn}, gates(k != 2, k == 2), "exit");
    diagClear = 1'h1;
    cyc(1);
    diagClear = 1'h0;
  endtask

  // ==========================================
  // Main sequence
  initial begin
    {rst_n, hostEn, hostDis, hostInA, hostInB, cfgWrite, diagClear, overTemp, underVolt} = 9'h0;
    {hostEnOe, hostDisOe, hostInOe} = 3'h7;
    {spiSel, spiA, spiB, flagMode, chA, chB, limitSel} = 8'h0C;
    {lsLimit, lsShut, hsShut} = 6'h00;
    cyc(5);
    rst_n = 1'h1;
    cyc(1);
    t_reset;
    t_drive;
    t_disable;
    t_spi;
    t_flag;
    for (int k = 0; k < 4; k++) t_fault(k);
    test_done;
  end

  initial begin
    #200000;
    n_mismatch++;
    test_done;
  end
endmodule  // tb_top
